/* File: hw/uiopm_pkg.sv */
// constants for the io and power control register block
// assumes the ulpi register port delivers decoded address, data and write strobes on mclk
// Contract
// - write at 0x39, set at 0x3a, clear at 0x3b; all three read same contents
// - swap bit one exchanges positive and negative data pin roles
// - in serial mode swap also exchanges transmit and receive pins
// - in audio mode swap leaves speaker routing untouched
// - serial level field bits 3:2 selects regulator level, resets to 01
// - entering serial mode, serial level applies once transmit drive enable asserts
// - audio mode forces regulator to highest level, code 00
// - bits 4 and 5 enable line pullups; serial mode forces both on
// - normal level field bits 7:6 uses same encoding, resets to 00
// - normal level applies in synchronous, serial-interface or low power modes
package uiopm_pkg;
  localparam logic [5:0] UIOPM_ADDR_WRITE = 6'h39;
  localparam logic [5:0] UIOPM_ADDR_SET = 6'h3a;
  localparam logic [5:0] UIOPM_ADDR_CLEAR = 6'h3b;
  localparam int UIOPM_SWAP_BIT = 1;
  localparam int UIOPM_SER_LVL_LO = 2;
  localparam int UIOPM_PLUS_PU_BIT = 4;
  localparam int UIOPM_MINUS_PU_BIT = 5;
  localparam int UIOPM_NRM_LVL_LO = 6;
  localparam logic [7:0] UIOPM_WRITABLE_MASK = 8'hfe;
  localparam logic [7:0] UIOPM_RESET_VALUE = 8'h04;
  localparam logic [1:0] UIOPM_LEVEL_3V3 = 2'h0;
  typedef enum logic [1:0] {
    UIOPM_MODE_NORMAL,
    UIOPM_MODE_SERIAL,
    UIOPM_MODE_AUDIO
  } uiopm_mode_e;
endpackage

/* File: hw/uiopm_level_sel.sv */
// regulator level selection from the two level fields and the operating mode
// assumes mode and transmit drive enable come from logic on mclk
`timescale 1ns/10ps
module uiopm_level_sel (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire uiopm_pkg::uiopm_mode_e mode,
  input wire logic serial_transmit_drive_enable,
  input wire logic [1:0] serial_mode_regulator_level,
  input wire logic [1:0] normal_mode_regulator_level,
  output logic [1:0] level_reg
);
  import uiopm_pkg::*;
  logic armed_reg;
  logic [1:0] level_next;

  // serial level latched in once drive enable seen after entering serial mode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else if (mode != UIOPM_MODE_SERIAL) begin
      armed_reg <= 1'b0;
    end else if (serial_transmit_drive_enable) begin
      armed_reg <= 1'b1;
    end
  end

  always_comb begin
    level_next = normal_mode_regulator_level;
    if (mode == UIOPM_MODE_AUDIO) begin
      level_next = UIOPM_LEVEL_3V3;
    end else if (mode == UIOPM_MODE_SERIAL && (armed_reg || serial_transmit_drive_enable)) begin
      level_next = serial_mode_regulator_level;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= UIOPM_LEVEL_3V3;
    end else begin
      level_reg <= level_next;
    end
  end
endmodule

/* File: hw/uiopm_top.sv */
// io and power control register with pin routing and regulator level control
// assumes the ulpi register engine on mclk presents address, data and a one-cycle write strobe
`timescale 1ns/10ps
module uiopm_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire uiopm_pkg::uiopm_mode_e mode,
  input wire logic serial_transmit_drive_enable,
  input wire logic xcvr_plus_tx,
  input wire logic xcvr_minus_tx,
  input wire logic uart_txd,
  input wire logic pin_plus_in,
  input wire logic pin_minus_in,
  input wire logic left_speaker_in,
  input wire logic right_speaker_in,
  output logic pin_plus_drv,
  output logic pin_minus_drv,
  output logic xcvr_plus_rx,
  output logic xcvr_minus_rx,
  output logic uart_rxd,
  output logic left_speaker_output,
  output logic right_speaker_output,
  output logic data_pin_swap,
  output logic plus_line_charger_pullup_enable,
  output logic minus_line_charger_pullup_enable,
  output logic [1:0] regulated_supply_output
);
  import uiopm_pkg::*;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [1:0] ser_lvl;
  logic [1:0] nrm_lvl;
  logic serial_mode;
  logic audio_mode;
  logic plus_meta_reg;
  logic plus_sync_reg;
  logic minus_meta_reg;
  logic minus_sync_reg;
  logic plus_drv_next;
  logic minus_drv_next;
  logic plus_rx_next;
  logic minus_rx_next;
  logic uart_rx_next;

  // true for any of the three aliases of the control register
  function automatic logic uiopm_is_ctrl_addr(input logic [5:0] addr);
    return (addr == UIOPM_ADDR_WRITE) || (addr == UIOPM_ADDR_SET) || (addr == UIOPM_ADDR_CLEAR);
  endfunction

  // register contents after one access; bit 0 never stores
  function automatic logic [7:0] uiopm_apply(
    input logic [5:0] addr,
    input logic [7:0] cur,
    input logic [7:0] wdata
  );
    logic [7:0] res;
    res = cur;
    if (addr == UIOPM_ADDR_WRITE) begin
      res = wdata;
    end else if (addr == UIOPM_ADDR_SET) begin
      res = cur | wdata;
    end else if (addr == UIOPM_ADDR_CLEAR) begin
      res = cur & ~wdata;
    end
    return res & UIOPM_WRITABLE_MASK;
  endfunction

  // the data pins come from the cable, so two flops guard against metastability
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      plus_meta_reg <= 1'b0;
      minus_meta_reg <= 1'b0;
    end else begin
      plus_meta_reg <= pin_plus_in;
      minus_meta_reg <= pin_minus_in;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      plus_sync_reg <= 1'b0;
      minus_sync_reg <= 1'b0;
    end else begin
      plus_sync_reg <= plus_meta_reg;
      minus_sync_reg <= minus_meta_reg;
    end
  end

  // the link leaves serial mode through the reset pin, which reaches us as sys_rst
  always_comb begin
    ctrl_next = ctrl_reg & UIOPM_WRITABLE_MASK;
    if (reg_wr && uiopm_is_ctrl_addr(reg_addr)) begin
      ctrl_next = uiopm_apply(reg_addr, ctrl_reg, reg_wdata);
    end
  end

  // reset puts the serial level field at its default code
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= UIOPM_RESET_VALUE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_comb begin
    reg_hit = uiopm_is_ctrl_addr(reg_addr);
    reg_rdata = reg_hit ? ctrl_reg : 8'h00;
  end

  assign serial_mode = (mode == UIOPM_MODE_SERIAL);
  assign audio_mode = (mode == UIOPM_MODE_AUDIO);
  assign data_pin_swap = ctrl_reg[UIOPM_SWAP_BIT];
  assign ser_lvl = ctrl_reg[UIOPM_SER_LVL_LO +: 2];
  assign nrm_lvl = ctrl_reg[UIOPM_NRM_LVL_LO +: 2];

  // pin routing; serial mode carries uart lines on the data pins
  // unswapped, transmit leaves on the plus pin and receive comes in on the minus pin
  always_comb begin
    plus_drv_next = data_pin_swap ? xcvr_minus_tx : xcvr_plus_tx;
    minus_drv_next = data_pin_swap ? xcvr_plus_tx : xcvr_minus_tx;
    plus_rx_next = data_pin_swap ? minus_sync_reg : plus_sync_reg;
    minus_rx_next = data_pin_swap ? plus_sync_reg : minus_sync_reg;
    uart_rx_next = 1'b0;
    if (serial_mode) begin
      plus_drv_next = data_pin_swap ? 1'b0 : uart_txd;
      minus_drv_next = data_pin_swap ? uart_txd : 1'b0;
      plus_rx_next = 1'b0;
      minus_rx_next = 1'b0;
      uart_rx_next = data_pin_swap ? plus_sync_reg : minus_sync_reg;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_plus_drv <= 1'b0;
    end else begin
      pin_plus_drv <= plus_drv_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_minus_drv <= 1'b0;
    end else begin
      pin_minus_drv <= minus_drv_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xcvr_plus_rx <= 1'b0;
    end else begin
      xcvr_plus_rx <= plus_rx_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xcvr_minus_rx <= 1'b0;
    end else begin
      xcvr_minus_rx <= minus_rx_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      uart_rxd <= 1'b0;
    end else begin
      uart_rxd <= uart_rx_next;
    end
  end

  // speakers never follow the swap bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      left_speaker_output <= 1'b0;
    end else begin
      left_speaker_output <= audio_mode & left_speaker_in;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      right_speaker_output <= 1'b0;
    end else begin
      right_speaker_output <= audio_mode & right_speaker_in;
    end
  end

  // serial mode forces both pullups whatever the register holds
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      plus_line_charger_pullup_enable <= 1'b0;
    end else begin
      plus_line_charger_pullup_enable <= serial_mode | ctrl_reg[UIOPM_PLUS_PU_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      minus_line_charger_pullup_enable <= 1'b0;
    end else begin
      minus_line_charger_pullup_enable <= serial_mode | ctrl_reg[UIOPM_MINUS_PU_BIT];
    end
  end

  // regulator level follows the mode; the selector keeps the serial arming
  uiopm_level_sel u_level (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mode(mode),
    .serial_transmit_drive_enable(serial_transmit_drive_enable),
    .serial_mode_regulator_level(ser_lvl),
    .normal_mode_regulator_level(nrm_lvl),
    .level_reg(regulated_supply_output)
  );
endmodule

/* File: verif/uiopm_monitor.sv */
// assertions on the io and power control register ports
// assumes binding into uiopm_top with the single clock mclk
`timescale 1ns/10ps
module uiopm_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_hit,
  input wire logic data_pin_swap,
  input wire logic left_speaker_in,
  input wire logic left_speaker_output,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire uiopm_pkg::uiopm_mode_e mode,
  input wire logic serial_transmit_drive_enable,
  input wire logic plus_line_charger_pullup_enable,
  input wire logic minus_line_charger_pullup_enable,
  input wire logic [1:0] regulated_supply_output,
  input wire logic xcvr_plus_tx,
  input wire logic xcvr_minus_tx,
  input wire logic uart_txd,
  input wire logic pin_plus_drv,
  input wire logic pin_minus_drv
);
  import uiopm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_bit0_zero: assert property (reg_rdata[0] == 1'b0) else $error("bit0 set");
  chk_hit_decode: assert property (reg_hit == (reg_addr inside {6'h39, 6'h3a, 6'h3b})) else $error("decode");
  chk_write_swap: assert property (reg_wr && reg_addr == 6'h39 |=>
    data_pin_swap == $past(reg_wdata[1])) else $error("write");
  chk_set_ors: assert property (reg_wr && reg_addr == 6'h3a && reg_wdata[1] |=> data_pin_swap) else $error("set");
  chk_clear_bits: assert property (reg_wr && reg_addr == 6'h3b && reg_wdata[1] |=> !data_pin_swap)
    else $error("clear");
  chk_audio_level: assert property (mode == UIOPM_MODE_AUDIO |=> regulated_supply_output == 2'h0) else $error("audio");
  chk_serial_pullups: assert property (mode == UIOPM_MODE_SERIAL |=>
    plus_line_charger_pullup_enable && minus_line_charger_pullup_enable) else $error("pullups");
  chk_normal_level: assert property (mode == UIOPM_MODE_NORMAL && reg_hit |=>
    regulated_supply_output == $past(reg_rdata[7:6])) else $error("normal level");
  chk_speaker_pass: assert property (mode == UIOPM_MODE_AUDIO |=>
    left_speaker_output == $past(left_speaker_in)) else $error("speaker");
  chk_usb_swap: assert property (mode != UIOPM_MODE_SERIAL && data_pin_swap |=>
    pin_plus_drv == $past(xcvr_minus_tx) && pin_minus_drv == $past(xcvr_plus_tx)) else $error("usb swap");
  chk_serial_swap: assert property (mode == UIOPM_MODE_SERIAL && data_pin_swap |=>
    pin_minus_drv == $past(uart_txd) && !pin_plus_drv) else $error("serial swap");
  chk_serial_level: assert property (mode == UIOPM_MODE_SERIAL && serial_transmit_drive_enable && reg_hit |=>
    regulated_supply_output == $past(reg_rdata[3:2])) else $error("serial level");
  cover property (mode == UIOPM_MODE_SERIAL && data_pin_swap);
  cover property (reg_wr && reg_addr == 6'h3a);
  cover property (reg_wr && reg_addr == 6'h3b);
  cover property (mode == UIOPM_MODE_AUDIO && data_pin_swap);
endmodule
bind uiopm_top uiopm_monitor u_mon (.*);

/* File: verif/uiopm_link.sv */
// link-side model driving the register port of the io and power block
// assumes the bench calls acc; requests change on falling edges only
`timescale 1ns/10ps
module uiopm_link (
  input wire logic mclk,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr
);
  initial {reg_addr, reg_wdata, reg_wr} = {6'h39, 8'h00, 1'b0};
  // one access driven at a falling edge and held until the next call
  task automatic acc(input logic [5:0] a, input logic [7:0] d, input logic w);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
  endtask
endmodule

/* File: verif/tb_uiopm_top.sv */
// self-checking bench for uiopm_top with a link model on the register port
// assumes the package constants and a 25 MHz mclk
`timescale 1ns/10ps
module tb_uiopm_top;
  import uiopm_pkg::*;
  logic mclk, sys_rst, reg_wr, reg_hit, chk, serial_transmit_drive_enable, arm;
  logic xcvr_plus_tx, xcvr_minus_tx, uart_txd, pin_plus_in, pin_minus_in, left_speaker_in, right_speaker_in;
  logic pin_plus_drv, pin_minus_drv, xcvr_plus_rx, xcvr_minus_rx, uart_rxd, left_speaker_output, right_speaker_output;
  logic data_pin_swap, plus_line_charger_pullup_enable, minus_line_charger_pullup_enable;
  logic [1:0] regulated_supply_output;
  logic [5:0] reg_addr, wa, ra;
  logic [7:0] reg_wdata, reg_rdata, m, d;
  logic [19:0] q[$], e, obs;
  uiopm_mode_e mode;
  int err_total = 0, n_tests = 0, cyc = 0, k, seed = 32'h81632ffd;
  uiopm_top u_dut (.*);
  uiopm_link u_link (.mclk, .reg_addr, .reg_wdata, .reg_wr);
  assign obs = {reg_rdata, reg_hit, regulated_supply_output, plus_line_charger_pullup_enable,
    minus_line_charger_pullup_enable, pin_plus_drv, pin_minus_drv, xcvr_plus_rx, xcvr_minus_rx, uart_rxd,
    left_speaker_output, right_speaker_output};
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // expected outputs: register view, level, pullups, then pin routing and speakers
  function automatic logic [19:0] model(input logic [5:0] a);
    logic hit, sw, ser;
    logic [1:0] lvl;
    logic [6:0] rt;
    hit = a inside {UIOPM_ADDR_WRITE, UIOPM_ADDR_SET, UIOPM_ADDR_CLEAR};
    sw = m[1];
    ser = mode == UIOPM_MODE_SERIAL;
    lvl = mode == UIOPM_MODE_AUDIO ? 2'h0 : (ser && arm) ? m[3:2] : m[7:6];
    rt[6:5] = ser ? (sw ? {1'b0, uart_txd} : {uart_txd, 1'b0}) :
      (sw ? {xcvr_minus_tx, xcvr_plus_tx} : {xcvr_plus_tx, xcvr_minus_tx});
    rt[4:3] = ser ? 2'h0 : (sw ? {pin_minus_in, pin_plus_in} : {pin_plus_in, pin_minus_in});
    rt[2] = ser & (sw ? pin_plus_in : pin_minus_in);
    rt[1:0] = mode == UIOPM_MODE_AUDIO ? {left_speaker_in, right_speaker_in} : 2'h0;
    return {hit ? m : 8'h00, hit, lvl, ser ? 2'h3 : {m[4], m[5]}, rt};
  endfunction
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      conclude;
    end else if (chk) begin
      e = q.pop_front();
      n_tests++;
      if (obs !== e) begin
        err_total++;
        $display("MISMATCH %0t got %h exp %h", $time, obs, e);
      end
    end
  end
  initial begin
    sys_rst = 1'b1;
    chk = 1'b0;
    serial_transmit_drive_enable = 1'b0;
    mode = UIOPM_MODE_NORMAL;
    arm = 1'b0;
    {xcvr_plus_tx, xcvr_minus_tx, uart_txd, pin_plus_in, pin_minus_in, left_speaker_in, right_speaker_in} = 7'h00;
    repeat (10) @(negedge mclk);
    sys_rst = 0;
    m = 8'h04;
    for (int i = 0; i < 60; i++) begin
      k = $unsigned($random(seed)) % 3;
      if (mode == UIOPM_MODE_SERIAL && k != 1) begin
        @(negedge mclk) sys_rst = 1;
        @(negedge mclk) sys_rst = 0;
        m = 8'h04;
        arm = 1'b0;
      end
      wa = i == 0 ? 6'h3c : 6'h39 + 6'($unsigned($random(seed)) % 4);
      d = 8'($random(seed));
      u_link.acc(wa, d, 1'b1);
      mode = uiopm_mode_e'(k[1:0]);
      serial_transmit_drive_enable = 1'($random(seed));
      arm = (mode == UIOPM_MODE_SERIAL) && (arm || serial_transmit_drive_enable);
      {xcvr_plus_tx, xcvr_minus_tx, uart_txd, pin_plus_in, pin_minus_in, left_speaker_in, right_speaker_in} = 7'($random(seed));
      if (wa == 6'h39) m = d & 8'hfe;
      else if (wa == 6'h3a) m = m | (d & 8'hfe);
      else if (wa == 6'h3b) m = m & ~d;
      ra = 6'h39 + 6'($unsigned($random(seed)) % 4);
      u_link.acc(ra, ~d, 1'b0);
      repeat (2) @(negedge mclk);
      q.push_back(model(ra));
      chk = 1;
      @(negedge mclk) chk = 0;
    end
    conclude;
  end
endmodule
